//--- pdp_handler.sv
// pci data parity error detection and reporting for the address translation unit
`timescale 1ns/10ps

// What this block does
// RULE1 - outbound write: target perr sampled with parity response set sets master parity flag
// RULE2 - after outbound write parity error, keep driving remaining data to drain the queue
// RULE3 - pci-x: perr after split response of non-posted write counts as write error
// RULE4 - master parity flag sets its interrupt-status bit when its mask is clear
// RULE5 - ordinary write error asserts serr only in pci-x, serr enabled, recover clear
// RULE6 - serr sets asserted flag, unmasked irq bit, and detected irq bit when enabled
// RULE7 - outbound write parity error gives no master completion on the internal bus
// RULE8 - on disconnect after write error, reinitiate as master until queue flushed
// RULE9 - msi write error: complete normally, then apply master parity flag handling
// RULE10 - msi write error asserts serr whenever serr enable and parity response are set, any mode
// RULE11 - pci-x inbound read split completion perr: finish normally, nothing more
// RULE12 - pci-x config write completion perr: finish normally, record nothing
// RULE13 - initiator may flag bad inbound read data; device as target does nothing
// RULE14 - inbound write error: keep accepting until initiator ends or queue full
// RULE15 - inbound write error drives perr 2 clocks later, 3 in pci-x, if enabled
// RULE16 - inbound write and read completion errors set detected flag and unmasked irq
// RULE17 - pci-x read completion error drives perr when enabled; that sets master flag
// RULE18 - read completion error sends internal message class 2h index 82h
// RULE19 - read completion error asserts serr when enabled and recover clear
// RULE20 - flags stay set until software clears; perr delay counted in bus clocks
module pdp_handler (
  input  wire logic                       core_clk,
  input  wire logic                       rst_n,
  input  wire pdp_pkg::pdp_cfg_type       cfg,
  input  wire pdp_pkg::pdp_flag_type      flag_clr,
  input  wire logic                       perr_n_i,
  input  wire logic                       ob_wr_active,
  input  wire logic                       ob_npw_split_win,
  input  wire logic                       ob_wr_disconnect,
  input  wire logic                       owq_empty,
  input  wire logic                       ob_msi_active,
  input  wire logic                       ob_msi_done,
  input  wire logic                       ib_wr_active,
  input  wire logic                       ib_wr_dphase,
  input  wire logic                       ib_wr_par_err,
  input  wire logic                       ib_queue_full,
  input  wire logic                       rdc_dphase,
  input  wire logic                       rdc_par_err,
  output logic                            perr_n_o,
  output logic                            perr_oe,
  output logic                            serr_n_o,
  output logic                            serr_oe,
  output pdp_pkg::pdp_flag_type           flags,
  output logic                            owq_drain,
  output logic                            ob_restart_req,
  output logic                            mst_cpl_block,
  output logic                            ib_wr_accept,
  output logic                            msg_valid,
  output pdp_pkg::pdp_msg_type            msg
);

  // ==========================================================================
  // helpers
  // ==========================================================================
  // interrupt-status set term: event gated by its mask
  function automatic logic irq_set(input logic ev, input logic mask);
    irq_set = ev & ~mask;
  endfunction

  pdp_pkg::pdp_flag_type     flags_q;
  pdp_pkg::pdp_flag_type     flags_d;
  pdp_pkg::pdp_ow_state_type ow_state_q;
  pdp_pkg::pdp_ow_state_type ow_state_d;
  logic [pdp_pkg::PERR_SR_LEN-1:0] perr_sr_q;
  logic [pdp_pkg::PERR_SR_LEN-1:0] rdc_sr_q;
  logic                      perr_q;
  logic                      serr_q;
  logic                      perr_n_q;
  logic                      serr_n_q;
  logic                      cpl_block_q;
  logic                      msi_perr_q;
  logic                      ib_accept_q;
  logic                      msg_valid_q;
  pdp_pkg::pdp_msg_type      msg_q;
  logic                      ow_perr;
  logic                      ib_err;
  logic                      rdc_err;
  logic                      perr_d;
  logic                      rdc_perr_d;
  logic                      msi_fire;
  logic                      mpe_ev;
  logic                      serr_d;

  // ==========================================================================
  // event decode
  // ==========================================================================
  // perr is only looked at while we master an outbound write or, in pci-x, in the split-response window after one; inbound
  // completions and inbound reads never reach any flag
  assign ow_perr  = ~perr_n_i & (ob_wr_active | (cfg.pcix_mode & ob_npw_split_win)); // [RULE3] [RULE11] [RULE12] [RULE13]
  assign ib_err   = ib_wr_dphase & ib_wr_par_err;
  assign rdc_err  = cfg.pcix_mode & rdc_dphase & rdc_par_err;
  // msi error is held until the write has completed normally
  assign msi_fire = ob_msi_done & (msi_perr_q | (~perr_n_i & ob_msi_active)); // [RULE9]

  // perr drive timing: tap the shift chain at the mode's delay
  assign perr_d = (~cfg.pcix_mode & perr_sr_q[pdp_pkg::PERR_DLY_CONV-2])
                | (cfg.pcix_mode & perr_sr_q[pdp_pkg::PERR_DLY_PCIX-2]); // [RULE15] [RULE17] [RULE20]
  assign rdc_perr_d = cfg.pcix_mode & rdc_sr_q[pdp_pkg::PERR_DLY_PCIX-2];

  // master parity error: write perr, msi done, or our own perr on read data
  assign mpe_ev = cfg.parity_resp_en & (ow_perr | msi_fire) | rdc_perr_d; // [RULE1] [RULE9] [RULE17]

  // serr decision per case
  assign serr_d = (cfg.parity_resp_en & ow_perr & cfg.pcix_mode & cfg.serr_en & ~cfg.dpe_recover_en) // [RULE5]
                | (cfg.parity_resp_en & msi_fire & cfg.serr_en)                                     // [RULE10]
                | (rdc_err & cfg.serr_en & ~cfg.dpe_recover_en);                                    // [RULE19]

  // ==========================================================================
  // perr delay chain
  // ==========================================================================
  // a bare shift chain, no counter, so back-to-back errored phases each get
  // their own perr clock
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      perr_sr_q <= '0;
      rdc_sr_q  <= '0;
    end else begin
      perr_sr_q <= {perr_sr_q[pdp_pkg::PERR_SR_LEN-2:0], cfg.parity_resp_en & (ib_err | rdc_err)}; // [RULE15]
      rdc_sr_q  <= {rdc_sr_q[pdp_pkg::PERR_SR_LEN-2:0], cfg.parity_resp_en & rdc_err};             // [RULE17]
    end
  end

  // ==========================================================================
  // pin drivers
  // ==========================================================================
  // both pins are low-active; enable is high only while we pull low.
  // level and enable get separate flops so neither pin goes through a gate
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      perr_q   <= 1'b0;
      perr_n_q <= 1'b1;
      serr_q   <= 1'b0;
      serr_n_q <= 1'b1;
    end else begin
      perr_q   <= perr_d;
      perr_n_q <= ~perr_d;
      serr_q   <= serr_d;
      serr_n_q <= ~serr_d;
    end
  end

  assign perr_n_o = perr_n_q;
  assign perr_oe  = perr_q;
  assign serr_n_o = serr_n_q;
  assign serr_oe  = serr_q;

  // ==========================================================================
  // msi pending error
  // ==========================================================================
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      msi_perr_q <= 1'b0;
    end else if (ob_msi_done) begin
      msi_perr_q <= 1'b0;
    end else if (ob_msi_active & ~perr_n_i) begin
      msi_perr_q <= 1'b1; // [RULE9]
    end
  end

  // ==========================================================================
  // sticky flags: a set in the clear cycle wins
  // ==========================================================================
  always_comb begin
    flags_d               = flags_q & ~flag_clr;
    flags_d.mpe           = flags_d.mpe | mpe_ev;                                       // [RULE1] [RULE20]
    flags_d.irq_mpe       = flags_d.irq_mpe | irq_set(mpe_ev, cfg.mpe_mask);             // [RULE4]
    flags_d.dpe           = flags_d.dpe | ib_err | rdc_err;                             // [RULE16]
    flags_d.irq_dpe       = flags_d.irq_dpe | irq_set(ib_err | rdc_err, cfg.dpe_mask);   // [RULE16]
    flags_d.serr_asrt     = flags_d.serr_asrt | serr_d;                                 // [RULE6]
    flags_d.irq_serr_asrt = flags_d.irq_serr_asrt | irq_set(serr_d, cfg.serr_asrt_mask); // [RULE6]
    flags_d.irq_serr_det  = flags_d.irq_serr_det | (serr_d & cfg.serr_det_irq_en);      // [RULE6]
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      flags_q <= pdp_pkg::FLAG_RESET;
    end else begin
      flags_q <= flags_d; // [RULE20]
    end
  end

  assign flags = flags_q;

  // ==========================================================================
  // internal bus error message for read completion errors
  // ==========================================================================
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      msg_valid_q <= 1'b0;
      msg_q       <= pdp_pkg::MSG_RESET;
    end else begin
      msg_valid_q <= rdc_err; // [RULE18]
      if (rdc_err) begin
        msg_q <= '{cls: pdp_pkg::MSG_CLASS_CPL_ERR, idx: pdp_pkg::MSG_IDX_RD_PAR}; // [RULE18]
      end
    end
  end

  assign msg_valid = msg_valid_q;
  assign msg       = msg_q;

  // ==========================================================================
  // inbound write acceptance
  // ==========================================================================
  // parity errors never throttle acceptance; only a full queue does
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ib_accept_q <= 1'b0;
    end else begin
      ib_accept_q <= ib_wr_active & ~ib_queue_full; // [RULE14]
    end
  end

  assign ib_wr_accept = ib_accept_q;

  // ==========================================================================
  // outbound write error sequencing
  // ==========================================================================
  always_comb begin
    ow_state_d = ow_state_q;
    case (ow_state_q)
      pdp_pkg::OW_IDLE: begin
        if (ow_perr) begin
          ow_state_d = pdp_pkg::OW_DRAIN; // [RULE2]
        end
      end
      pdp_pkg::OW_DRAIN: begin
        if (owq_empty) begin
          ow_state_d = pdp_pkg::OW_IDLE;
        end else if (ob_wr_disconnect) begin
          ow_state_d = pdp_pkg::OW_RESTART; // [RULE8]
        end
      end
      pdp_pkg::OW_RESTART: begin
        if (owq_empty) begin
          ow_state_d = pdp_pkg::OW_IDLE;
        end else if (ob_wr_active) begin
          ow_state_d = pdp_pkg::OW_DRAIN; // [RULE8]
        end
      end
      default: begin
        ow_state_d = pdp_pkg::OW_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ow_state_q <= pdp_pkg::OW_RESET;
    end else begin
      ow_state_q <= ow_state_d;
    end
  end

  // completion suppression has its own flop so the pin carries no gate
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cpl_block_q <= 1'b0;
    end else begin
      cpl_block_q <= (ow_state_d != pdp_pkg::OW_IDLE); // [RULE7]
    end
  end

  // one-hot bits are the outputs themselves
  assign owq_drain      = ow_state_q[1]; // [RULE2]
  assign ob_restart_req = ow_state_q[2]; // [RULE8]
  assign mst_cpl_block  = cpl_block_q;   // [RULE7]

  // ==========================================================================
  // checks
  // ==========================================================================
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  perr_conv_delay_a: assert property (ib_err && cfg.parity_resp_en && !cfg.pcix_mode ##1 !cfg.pcix_mode |-> ##1 perr_oe) // [RULE15]
    else $error("perr not driven two clocks after conventional inbound error");
  perr_pcix_delay_a: assert property (ib_err && cfg.parity_resp_en && cfg.pcix_mode ##1 cfg.pcix_mode[*2] |=> perr_oe) // [RULE15]
    else $error("perr not driven three clocks after pci-x inbound error");
  perr_gate_a: assert property (!cfg.parity_resp_en[*3] |=> !perr_oe) // [RULE15]
    else $error("perr driven with parity response off");
  mpe_write_a: assert property (ow_perr && cfg.parity_resp_en |=> flags.mpe) // [RULE1]
    else $error("master parity flag missed on write perr");
  mpe_irq_a: assert property ($rose(flags.mpe) && $past(!cfg.mpe_mask) |-> flags.irq_mpe) // [RULE4]
    else $error("master parity irq bit not set");
  serr_conv_a: assert property (!cfg.pcix_mode && !msi_fire && !rdc_err |=> !serr_oe) // [RULE5]
    else $error("serr on conventional ordinary write");
  serr_flag_a: assert property (serr_oe |-> flags.serr_asrt) // [RULE6]
    else $error("serr asserted flag not set");
  msi_serr_a: assert property (msi_fire && cfg.parity_resp_en && cfg.serr_en |=> serr_oe ##0 flags.mpe) // [RULE10]
    else $error("msi error missed serr");
  msg_code_a: assert property (rdc_err |=> msg_valid && msg.cls == 4'h2 && msg.idx == 8'h82) // [RULE18]
    else $error("bad read parity message");
  drain_hold_a: assert property (ow_perr && !owq_empty |=> mst_cpl_block) // [RULE7]
    else $error("master completion not blocked after write error");
  sticky_a: assert property (flags.dpe && !flag_clr.dpe |=> flags.dpe) // [RULE20]
    else $error("detected parity flag lost without clear");
  drain_disconnect_a: assert property (owq_drain && !owq_empty && ob_wr_disconnect |=> ob_restart_req) // [RULE8]
    else $error("no restart after disconnect with queued data");
  restart_drain_a: assert property (ob_restart_req && !owq_empty && ob_wr_active |=> owq_drain) // [RULE8]
    else $error("restarted write not draining");
  ib_accept_a: assert property (ib_wr_active && !ib_queue_full |=> ib_wr_accept) // [RULE14]
    else $error("inbound write not accepted");
  dpe_irq_a: assert property (ib_err && !cfg.dpe_mask |=> flags.dpe && flags.irq_dpe) // [RULE16]
    else $error("detected parity irq bit not set");
  rdc_mpe_a: assert property (rdc_err && cfg.parity_resp_en ##1 cfg.pcix_mode[*2] |=> perr_oe && flags.mpe) // [RULE17]
    else $error("read completion perr or master flag missed");
  serr_det_a: assert property (serr_oe && $past(cfg.serr_det_irq_en) |-> flags.irq_serr_det) // [RULE6]
    else $error("serr detected irq bit not set");
  ignore_perr_a: assert property (!ob_wr_active && !ob_npw_split_win && !ob_msi_done // [RULE11] [RULE13]
    && !rdc_perr_d |=> !$rose(flags.mpe))
    else $error("master parity flag set outside a mastered write");

endmodule

//--- pdp_pci_agent.sv
// far-side pci agent model that may pull the shared perr# wire low
`timescale 1ns/10ps

// ============================================================================
// shared perr# wire
// ============================================================================
module pdp_pci_agent (
  input  wire logic rst_n,
  input  wire logic report,
  input  wire logic dev_perr_n,
  input  wire logic dev_perr_oe,
  output logic      perr_wire
);
  logic agent_drv;

  // agent reports bad data only when out of reset
  assign agent_drv = report & rst_n;
  // pulled up: idle wire reads high, any driver low wins
  assign perr_wire = ~(agent_drv | (dev_perr_oe & ~dev_perr_n));
endmodule

//--- pdp_pkg.sv
// package of constants and carrier types for the pci data parity error handler
package pdp_pkg;

  // ==========================================================================
  // timing, counted in pci bus clocks
  // ==========================================================================
  localparam int unsigned PERR_DLY_CONV = 2; // clocks after errored data phase
  localparam int unsigned PERR_DLY_PCIX = 3;
  localparam int unsigned PERR_SR_LEN   = PERR_DLY_PCIX - 1;

  // ==========================================================================
  // internal bus completer error message
  // ==========================================================================
  localparam logic [3:0] MSG_CLASS_CPL_ERR = 4'h2; // completer error
  localparam logic [7:0] MSG_IDX_RD_PAR    = 8'h82; // bus read parity error

  // ==========================================================================
  // carriers
  // ==========================================================================
  // configuration and mask bits, held by software elsewhere
  typedef struct packed {
    logic parity_resp_en;
    logic serr_en;
    logic dpe_recover_en;
    logic pcix_mode;
    logic serr_det_irq_en;
    logic mpe_mask;
    logic serr_asrt_mask;
    logic dpe_mask;
  } pdp_cfg_type;

  // sticky status and interrupt-status bits
  typedef struct packed {
    logic mpe;
    logic dpe;
    logic serr_asrt;
    logic irq_mpe;
    logic irq_dpe;
    logic irq_serr_asrt;
    logic irq_serr_det;
  } pdp_flag_type;

  typedef struct packed {
    logic [3:0] cls;
    logic [7:0] idx;
  } pdp_msg_type;

  localparam pdp_flag_type FLAG_RESET = 7'h00;
  localparam pdp_msg_type  MSG_RESET  = 12'h000;

  // outbound write error handling
  typedef enum logic [2:0] {
    OW_IDLE    = 3'b001,
    OW_DRAIN   = 3'b010,
    OW_RESTART = 3'b100
  } pdp_ow_state_type;

  localparam pdp_ow_state_type OW_RESET = OW_IDLE;

endpackage

//--- tb_pdp_handler.sv
// self-checking testbench for the pci data parity error handler
`timescale 1ns/10ps

module tb_pdp_handler;
  // ==========================================================================
  // signals
  // ==========================================================================
  logic                  core_clk = 1'b0;
  logic                  rst_n = 1'b0;
  pdp_pkg::pdp_cfg_type  cfg = '0;
  pdp_pkg::pdp_flag_type flag_clr = '0;
  logic                  perr_wire, report = 1'b0;
  logic                  ob_wr_active = 1'b0, ob_npw_split_win = 1'b0, ob_wr_disconnect = 1'b0;
  logic                  owq_empty = 1'b1, ob_msi_active = 1'b0, ob_msi_done = 1'b0;
  logic                  ib_wr_active = 1'b0, ib_wr_dphase = 1'b0, ib_wr_par_err = 1'b0;
  logic                  ib_queue_full = 1'b0, rdc_dphase = 1'b0, rdc_par_err = 1'b0;
  logic                  perr_n_o, perr_oe, serr_n_o, serr_oe;
  logic                  owq_drain, ob_restart_req, mst_cpl_block, ib_wr_accept, msg_valid;
  pdp_pkg::pdp_flag_type flags;
  pdp_pkg::pdp_msg_type  msg;
  int                    fails = 0;
  int                    total_checks = 0;

  // 40 mhz clock
  always #12.5 core_clk = ~core_clk;

  pdp_handler pdp_handler_i (.core_clk(core_clk), .rst_n(rst_n), .cfg(cfg), .flag_clr(flag_clr),
    .perr_n_i(perr_wire), .ob_wr_active(ob_wr_active), .ob_npw_split_win(ob_npw_split_win),
    .ob_wr_disconnect(ob_wr_disconnect), .owq_empty(owq_empty), .ob_msi_active(ob_msi_active),
    .ob_msi_done(ob_msi_done), .ib_wr_active(ib_wr_active), .ib_wr_dphase(ib_wr_dphase),
    .ib_wr_par_err(ib_wr_par_err), .ib_queue_full(ib_queue_full), .rdc_dphase(rdc_dphase),
    .rdc_par_err(rdc_par_err), .perr_n_o(perr_n_o), .perr_oe(perr_oe), .serr_n_o(serr_n_o),
    .serr_oe(serr_oe), .flags(flags), .owq_drain(owq_drain), .ob_restart_req(ob_restart_req),
    .mst_cpl_block(mst_cpl_block), .ib_wr_accept(ib_wr_accept), .msg_valid(msg_valid), .msg(msg));

  pdp_pci_agent pdp_pci_agent_i (.rst_n(rst_n), .report(report), .dev_perr_n(perr_n_o),
    .dev_perr_oe(perr_oe), .perr_wire(perr_wire));

  // ==========================================================================
  // compare and closing tasks
  // ==========================================================================
  task automatic chk1(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_flags(input pdp_pkg::pdp_flag_type got, input pdp_pkg::pdp_flag_type exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_msg(input pdp_pkg::pdp_msg_type got, input pdp_pkg::pdp_msg_type exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // expectations; kind 0 write, 1 msi, 2 inbound write, 3 read completion, 4 none of ours
  // ==========================================================================
  function automatic logic exp_serr(input int k, input pdp_pkg::pdp_cfg_type c);
    case (k)
      0: return c.parity_resp_en & c.pcix_mode & c.serr_en & ~c.dpe_recover_en;
      1: return c.parity_resp_en & c.serr_en;
      3: return c.serr_en & ~c.dpe_recover_en;
      default: return 1'b0;
    endcase
  endfunction

  function automatic pdp_pkg::pdp_flag_type exp_flags(input int k, input pdp_pkg::pdp_cfg_type c);
    pdp_pkg::pdp_flag_type f;
    logic                  s;
    s = exp_serr(k, c);
    f.mpe = (k <= 1 || k == 3) && c.parity_resp_en;
    f.irq_mpe = f.mpe & ~c.mpe_mask;
    f.dpe = (k == 2 || k == 3);
    f.irq_dpe = f.dpe & ~c.dpe_mask;
    f.serr_asrt = s;
    f.irq_serr_asrt = s & ~c.serr_asrt_mask;
    f.irq_serr_det = s & c.serr_det_irq_en;
    return f;
  endfunction

  // ==========================================================================
  // one error event with random configuration, all inputs driven at falling edge
  // ==========================================================================
  task automatic run_event(input int k);
    logic [31:0]          r;
    pdp_pkg::pdp_cfg_type c;
    logic                 v, pr;
    int                   d;
    r = $urandom;
    c = pdp_pkg::pdp_cfg_type'(r[7:0]);
    if (k == 3) c.pcix_mode = 1'b1;
    v = r[8] & c.pcix_mode & (k == 0);
    @(negedge core_clk);
    cfg = c;
    flag_clr = '1;
    @(negedge core_clk);
    flag_clr = '0;
    owq_empty = (k != 0);
    ob_msi_active = (k == 1);
    report = (k == 1);
    @(negedge core_clk);
    // errored cycle: the event under test is presented here
    report = (k == 0 || k == 4);
    ob_wr_active = (k == 0) & ~v;
    ob_npw_split_win = v;
    ob_msi_done = (k == 1);
    {ib_wr_active, ib_wr_dphase, ib_wr_par_err} = {3{k == 2}};
    ib_queue_full = r[9];
    {rdc_dphase, rdc_par_err} = {2{k == 3}};
    d = (k == 3 || c.pcix_mode) ? 3 : 2;
    pr = c.parity_resp_en && (k == 2 || k == 3);
    for (int i = 1; i <= 4; i++) begin
      @(negedge core_clk);
      {report, ob_wr_active, ob_npw_split_win, ob_msi_active, ob_msi_done} = '0;
      {ib_wr_active, ib_wr_dphase, ib_wr_par_err, rdc_dphase, rdc_par_err} = '0;
      chk1(perr_oe, pr && i == d);
      chk1(perr_n_o, !(pr && i == d));
      chk1(serr_oe, i == 1 && exp_serr(k, c));
      chk1(serr_n_o, !(i == 1 && exp_serr(k, c)));
      if (i == 1) begin
        chk1(msg_valid, k == 3);
        if (k == 3) chk_msg(msg, {4'h2, 8'h82});
        if (k == 2) chk1(ib_wr_accept, !ib_queue_full);
        if (k == 0 && !v && c.parity_resp_en) chk1(owq_drain & mst_cpl_block, 1'b1);
      end
    end
    chk_flags(flags, exp_flags(k, c));
    // disconnect while the queue still holds data: restart until drained
    if (k == 0 && !v && c.parity_resp_en) begin
      ob_wr_disconnect = 1'b1;
      @(negedge core_clk);
      ob_wr_disconnect = 1'b0;
      chk1(ob_restart_req & mst_cpl_block, 1'b1);
      ob_wr_active = 1'b1;
      @(negedge core_clk);
      ob_wr_active = 1'b0;
      chk1(owq_drain, 1'b1);
      owq_empty = 1'b1;
      @(negedge core_clk);
      chk1(owq_drain | ob_restart_req | mst_cpl_block, 1'b0);
    end
    owq_empty = 1'b1;
    repeat (2) @(negedge core_clk);
  endtask

  // ==========================================================================
  // main sequence: every kind once, then a random mix
  // ==========================================================================
  initial begin
    void'($urandom(32'h735471c1));
    repeat (16) @(posedge core_clk);
    @(negedge core_clk);
    rst_n = 1'b1;
    @(negedge core_clk);
    chk_flags(flags, '0);
    chk1(perr_oe | serr_oe | msg_valid | owq_drain | mst_cpl_block, 1'b0);
    chk1(perr_n_o & serr_n_o, 1'b1);
    for (int k = 0; k <= 4; k++) run_event(k);
    for (int n = 0; n < 80; n++) run_event($urandom_range(0, 4));
    stop_test();
  end

  // watchdog well beyond the roughly 800 cycles the run needs
  initial begin
    #(25 * 20000);
    fails++;
    stop_test();
  end
endmodule
